// ===== piep_cfg.svh
// Register offsets, reset values and bit positions of the port interrupt block
`ifndef PIEP_CFG_SVH
`define PIEP_CFG_SVH
`define PIEP_OFS_PA_EN_HIGH 12'h0fc4
`define PIEP_OFS_PA_EN_LOW 12'h0fc5
`define PIEP_OFS_PC_EN_HIGH 12'h0fc7
`define PIEP_OFS_PC_EN_LOW 12'h0fc8
`define PIEP_OFS_EDGE_SEL 12'h0fcd
`define PIEP_OFS_REQ_A 12'h0fd0
`define PIEP_OFS_REQ_C 12'h0fd1
`define PIEP_OFS_CTRL 12'h0fd2
`define PIEP_OFS_STATUS 12'h0fd3
`define PIEP_OFS_MASK 12'h0fd4
`define PIEP_RESET_BYTE 8'h00
`define PIEP_PC_USED 4
`define PIEP_CTRL_MASTER_BIT 7
`define PIEP_CTRL_PORTD_LSB 0
`define PIEP_CTRL_SHARED_BIT 6
`define PIEP_STS_ACTIVE_BIT 0
`endif

// ===== piep_pkg.sv
// Types of the port interrupt block
package piep_pkg;
    typedef enum logic [1:0] {
        PIEP_OFF,
        PIEP_LEVEL1,
        PIEP_LEVEL2,
        PIEP_LEVEL3
    } piep_level_t;
    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic stb;
        logic cyc;
    } piep_wb_req_t;
    typedef struct packed {
        logic valid;
        logic group_c;
        logic [2:0] index;
        piep_level_t level;
    } piep_claim_t;
endpackage

// ===== piep_top.sv
// Port interrupt enable, priority and edge logic with Wishbone registers
`timescale 1ns/1ps
`include "piep_cfg.svh"

// Notes on behaviour
// (R1) Each high and low enable pair means disabled, level 1, level 2 or level 3.
// (R2) Port A enable bit x applies to request bit x of the second group, bits 7 to 0.
// (R3) Port C enable bit x applies to request bit x of the third group.
// (R4) Bit 6 of the port A pair governs the pin 6 or comparator shared source.
// (R5) Bits 5 to 0 of the port A pair take Port A or Port D as chosen by port select.
// (R6) Port C pair bits 3 to 0 govern Port C pins 3 to 0.
// (R7) Software writes zero to port C enable bits 7 to 4, which are reserved.
// (R8) Edge bit 0 raises a request on the falling edge of the selected pin.
// (R9) Edge bit 1 raises a request on the rising edge of the selected pin.
// (R10) The edge register holds one bit per position 7 to 0 for the selected input.
// (R11) A signalled request sets its request bit, held until cleared, readable and writable.
// (R12) Enabled requests reach the processor only while the master enable is 1.
// (R13) Software disables a shared interrupt before switching its source.
// (R14) The highest pending enabled level is presented, ties to port A over port C, then by lowest index.
// (R15) Enable and edge bits reset to 0: disabled and falling edge.
module piep_top (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire piep_pkg::piep_wb_req_t WB_REQ,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [7:0] PORT_A_PIN_INPUT,
    input wire logic [5:0] PORT_D_PIN_INPUT,
    input wire logic COMPARATOR_OUT,
    input wire logic [3:0] PORT_C_PIN_INPUT,
    input wire logic CPU_ACK,
    output logic CPU_IRQ,
    output piep_pkg::piep_claim_t CPU_CLAIM,
    output logic IRQ_OUT
);
    logic [7:0] port_a_enable_high;
    logic [7:0] port_a_enable_low;
    logic [7:0] port_c_enable_high;
    logic [7:0] port_c_enable_low;
    logic [7:0] edge_polarity_select;
    logic [7:0] ctrl;
    logic [7:0] second_request_group;
    logic [3:0] third_request_group;
    logic status;
    logic mask;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [7:0] pa_prev;
    logic [5:0] pd_s1;
    logic [5:0] pd_s2;
    logic [3:0] pc_s1;
    logic [3:0] pc_s2;
    logic [3:0] pc_prev;
    logic cmp_s1;
    logic cmp_s2;
    logic [7:0] sel_in;
    logic [7:0] a_edge;
    logic [3:0] c_edge;
    logic wr;
    logic rd_ack;
    logic [11:0] ofs;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    piep_pkg::piep_claim_t next_claim;
    logic master_interrupt_enable;
    logic cpu_ack_s1;
    logic cpu_ack_s2;

    // Pair of enable bits to a level
    function automatic piep_pkg::piep_level_t level_of(input logic h, input logic l);
        level_of = piep_pkg::piep_level_t'({h, l}); // (R1)
    endfunction

    // Write strobe aimed at one register offset
    function automatic logic hit(input logic w, input logic [11:0] a, input logic [11:0] o);
        hit = w && (a == o);
    endfunction

    // Strobe decode, write lands on the acknowledge edge
    assign wr = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & WB_ACK_O & WB_REQ.sel[0];
    assign rd_ack = WB_REQ.cyc & WB_REQ.stb & ~WB_ACK_O;
    assign ofs = WB_REQ.adr[13:2];
    assign wbyte = WB_REQ.dat[7:0];
    assign master_interrupt_enable = ctrl[`PIEP_CTRL_MASTER_BIT];

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= rd_ack;
        end
    end

    // Input synchronisers, two flops per pin group
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            pa_s1 <= 8'h00;
            pa_s2 <= 8'h00;
        end else begin
            pa_s1 <= PORT_A_PIN_INPUT;
            pa_s2 <= pa_s1;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            pd_s1 <= 6'h00;
            pd_s2 <= 6'h00;
        end else begin
            pd_s1 <= PORT_D_PIN_INPUT;
            pd_s2 <= pd_s1;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            pc_s1 <= 4'h0;
            pc_s2 <= 4'h0;
        end else begin
            pc_s1 <= PORT_C_PIN_INPUT;
            pc_s2 <= pc_s1;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
        end else begin
            cmp_s1 <= COMPARATOR_OUT;
            cmp_s2 <= cmp_s1;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            cpu_ack_s1 <= 1'b0;
            cpu_ack_s2 <= 1'b0;
        end else begin
            cpu_ack_s1 <= CPU_ACK;
            cpu_ack_s2 <= cpu_ack_s1;
        end
    end

    // Source selection per position
    always_comb begin
        sel_in[7] = pa_s2[7];
        sel_in[6] = ctrl[`PIEP_CTRL_SHARED_BIT] ? cmp_s2 : pa_s2[6]; // (R4)
        for (int i = 0; i < 6; i++) begin
            sel_in[i] = ctrl[`PIEP_CTRL_PORTD_LSB + i] ? pd_s2[i] : pa_s2[i]; // (R5)
        end
    end

    // Previous levels for edge detection
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            pa_prev <= 8'h00;
        end else begin
            pa_prev <= sel_in;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            pc_prev <= 4'h0;
        end else begin
            pc_prev <= pc_s2;
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (edge_polarity_select[i]) begin // (R10)
                a_edge[i] = sel_in[i] & ~pa_prev[i]; // (R9)
            end else begin
                a_edge[i] = ~sel_in[i] & pa_prev[i]; // (R8)
            end
        end
        c_edge = ~pc_s2 & pc_prev;
    end

    // Configuration registers, one per block
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            port_a_enable_high <= `PIEP_RESET_BYTE; // (R15)
        end else if (hit(wr, ofs, `PIEP_OFS_PA_EN_HIGH)) begin
            port_a_enable_high <= wbyte;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            port_a_enable_low <= `PIEP_RESET_BYTE; // (R15)
        end else if (hit(wr, ofs, `PIEP_OFS_PA_EN_LOW)) begin
            port_a_enable_low <= wbyte;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            port_c_enable_high <= `PIEP_RESET_BYTE; // (R15)
        end else if (hit(wr, ofs, `PIEP_OFS_PC_EN_HIGH)) begin
            port_c_enable_high <= wbyte;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            port_c_enable_low <= `PIEP_RESET_BYTE; // (R15)
        end else if (hit(wr, ofs, `PIEP_OFS_PC_EN_LOW)) begin
            port_c_enable_low <= wbyte;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            edge_polarity_select <= `PIEP_RESET_BYTE; // (R15)
        end else if (hit(wr, ofs, `PIEP_OFS_EDGE_SEL)) begin
            edge_polarity_select <= wbyte;
        end
    end

    // Control, master enable dropped on acknowledge
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl <= `PIEP_RESET_BYTE;
        end else begin
            if (hit(wr, ofs, `PIEP_OFS_CTRL)) begin
                ctrl <= wbyte;
            end
            if (CPU_IRQ && cpu_ack_s2) begin
                ctrl[`PIEP_CTRL_MASTER_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            mask <= 1'b0;
        end else if (hit(wr, ofs, `PIEP_OFS_MASK)) begin
            mask <= wbyte[`PIEP_STS_ACTIVE_BIT];
        end
    end

    // Request flags, set wins over clear
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            second_request_group <= 8'h00;
        end else begin
            if (hit(wr, ofs, `PIEP_OFS_REQ_A)) begin
                second_request_group <= wbyte | a_edge; // (R11)
            end else begin
                second_request_group <= second_request_group | a_edge; // (R11)
            end
            if (CPU_IRQ && cpu_ack_s2 && !CPU_CLAIM.group_c) begin
                second_request_group[CPU_CLAIM.index] <= a_edge[CPU_CLAIM.index];
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            third_request_group <= 4'h0;
        end else begin
            if (hit(wr, ofs, `PIEP_OFS_REQ_C)) begin
                third_request_group <= wbyte[3:0] | c_edge; // (R11)
            end else begin
                third_request_group <= third_request_group | c_edge; // (R11)
            end
            if (CPU_IRQ && cpu_ack_s2 && CPU_CLAIM.group_c) begin
                third_request_group[CPU_CLAIM.index[1:0]] <= c_edge[CPU_CLAIM.index[1:0]];
            end
        end
    end

    // Highest level, port A before port C among equals, then lowest index
    always_comb begin
        piep_pkg::piep_level_t lv;
        next_claim = '0;
        lv = piep_pkg::PIEP_OFF;
        for (int i = 7; i >= 0; i--) begin
            lv = level_of(port_a_enable_high[i], port_a_enable_low[i]); // (R2)
            if (second_request_group[i] && lv != piep_pkg::PIEP_OFF
                && lv >= next_claim.level) begin // (R14)
                next_claim.valid = 1'b1;
                next_claim.group_c = 1'b0;
                next_claim.index = 3'(i);
                next_claim.level = lv;
            end
        end
        for (int i = 0; i < `PIEP_PC_USED; i++) begin
            lv = level_of(port_c_enable_high[i], port_c_enable_low[i]); // (R3) (R6)
            if (third_request_group[i] && lv != piep_pkg::PIEP_OFF
                && lv > next_claim.level) begin // (R14)
                next_claim.valid = 1'b1;
                next_claim.group_c = 1'b1;
                next_claim.index = 3'(i);
                next_claim.level = lv;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            CPU_CLAIM <= '0;
            CPU_IRQ <= 1'b0;
        end else begin
            CPU_CLAIM <= next_claim;
            CPU_IRQ <= next_claim.valid & master_interrupt_enable; // (R12)
        end
    end

    // Sticky status of a presented request
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            status <= 1'b0;
        end else if (CPU_IRQ) begin
            status <= 1'b1;
        end else if (wr && ofs == `PIEP_OFS_STATUS && wbyte[`PIEP_STS_ACTIVE_BIT]) begin
            status <= 1'b0;
        end
    end

    assign IRQ_OUT = status & mask;

    // Read mux
    always_comb begin
        unique case (ofs)
            `PIEP_OFS_PA_EN_HIGH: rbyte = port_a_enable_high;
            `PIEP_OFS_PA_EN_LOW: rbyte = port_a_enable_low;
            `PIEP_OFS_PC_EN_HIGH: rbyte = port_c_enable_high;
            `PIEP_OFS_PC_EN_LOW: rbyte = port_c_enable_low;
            `PIEP_OFS_EDGE_SEL: rbyte = edge_polarity_select;
            `PIEP_OFS_REQ_A: rbyte = second_request_group;
            `PIEP_OFS_REQ_C: rbyte = {4'h0, third_request_group};
            `PIEP_OFS_CTRL: rbyte = ctrl;
            `PIEP_OFS_STATUS: rbyte = {7'h00, status};
            `PIEP_OFS_MASK: rbyte = {7'h00, mask};
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (rd_ack) begin
            WB_DAT_O <= {24'h00_0000, rbyte};
        end
    end
endmodule // piep_top

// ===== piep_top_properties.sv
// Port assertions of the port interrupt block
`timescale 1ns/1ps
module piep_top_properties (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire piep_pkg::piep_wb_req_t WB_REQ,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic CPU_IRQ,
    input wire piep_pkg::piep_claim_t CPU_CLAIM
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    property p_rst; $rose(RSTN) |-> !WB_ACK_O && !CPU_IRQ; endproperty
    a_rst: assert property (p_rst) else $error("output set after reset");
    property p_take; WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O |=> WB_ACK_O; endproperty
    a_take: assert property (p_take) else $error("request not acked");
    property p_idle; !(WB_REQ.cyc && WB_REQ.stb) |=> !WB_ACK_O; endproperty
    a_idle: assert property (p_idle) else $error("ack without request");
    property p_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long");
    property p_upper; WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_irq; CPU_IRQ |-> CPU_CLAIM.valid; endproperty
    a_irq: assert property (p_irq) else $error("irq without claim");
    property p_level; CPU_CLAIM.valid |-> CPU_CLAIM.level != piep_pkg::PIEP_OFF; endproperty
    a_level: assert property (p_level) else $error("claim of disabled level");
    property p_grpc; CPU_CLAIM.valid && CPU_CLAIM.group_c |-> !CPU_CLAIM.index[2]; endproperty
    a_grpc: assert property (p_grpc) else $error("port c index too high");
endmodule // piep_top_properties
bind piep_top piep_top_properties chk (.CLOCK, .RSTN, .WB_REQ, .WB_DAT_O, .WB_ACK_O,
    .CPU_IRQ, .CPU_CLAIM);

// ===== piep_core_model.sv
// Core model acknowledging presented interrupt claims
`timescale 1ns/1ps
module piep_core_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic en,
    input wire logic irq,
    output logic ack
);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
        end else begin
            ack <= en && irq;
        end
    end
endmodule // piep_core_model

// ===== port_interrupt_enable_priority_test.sv
// Self-checking bench of the port interrupt block
`timescale 1ns/1ps
`include "piep_cfg.svh"
module port_interrupt_enable_priority_test;
    localparam logic [11:0] ah = `PIEP_OFS_PA_EN_HIGH, al = `PIEP_OFS_PA_EN_LOW;
    localparam logic [11:0] ch = `PIEP_OFS_PC_EN_HIGH, cl = `PIEP_OFS_PC_EN_LOW;
    localparam logic [11:0] es = `PIEP_OFS_EDGE_SEL, ra = `PIEP_OFS_REQ_A, rc = `PIEP_OFS_REQ_C;
    localparam logic [11:0] ct = `PIEP_OFS_CTRL, st = `PIEP_OFS_STATUS, mk = `PIEP_OFS_MASK;
    logic clock = 1'b0, rstn = 1'b0, ack_en = 1'b0, cmp = 1'b1;
    logic ack_o, cpu_ack, cpu_irq, irq_out;
    logic [7:0] pa = 8'hff, rd;
    logic [5:0] pd = 6'h3f;
    logic [3:0] pc = 4'hf;
    logic [31:0] dat_o;
    piep_pkg::piep_wb_req_t req = '0;
    piep_pkg::piep_claim_t claim;
    int fail_count = 0, tests_run = 0;
    always #12.5 clock = ~clock;
    piep_top uut (.CLOCK(clock), .RSTN(rstn), .WB_REQ(req), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack_o), .PORT_A_PIN_INPUT(pa), .PORT_D_PIN_INPUT(pd), .COMPARATOR_OUT(cmp),
        .PORT_C_PIN_INPUT(pc), .CPU_ACK(cpu_ack), .CPU_IRQ(cpu_irq), .CPU_CLAIM(claim),
        .IRQ_OUT(irq_out));
    piep_core_model core (.clock(clock), .rstn(rstn), .en(ack_en), .irq(cpu_irq), .ack(cpu_ack));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [11:0] ofs, input logic [7:0] d, input logic we = 1'b1);
        req <= {18'h0, ofs, 2'h0, 24'h0, d, 4'h1, we, 2'h3};
        do @(posedge clock); while (ack_o !== 1'b1);
        rd = dat_o[7:0];
        req <= '0;
        @(posedge clock);
    endtask
    task automatic rchk(input logic [11:0] ofs, input logic [7:0] exp);
        w(ofs, 8'h00, 1'b0);
        chk(rd, exp);
    endtask
    task automatic settle;
        repeat (10) @(posedge clock);
    endtask
    task automatic t_reset;
        logic [11:0] offs [5] = '{ah, al, ch, cl, es};
        foreach (offs[i]) rchk(offs[i], 8'h00);
        w(12'h0fc9, 8'hff);
        rchk(12'h0fc9, 8'h00);
    endtask
    task automatic t_edges;
        w(al, 8'h81);
        w(es, 8'h80);
        pa <= 8'h7e;
        settle;
        rchk(ra, 8'h01);
        pa <= 8'hff;
        settle;
        rchk(ra, 8'h81);
        rchk(es, 8'h80);
        chk(cpu_irq, 1'b0);
        w(ra, 8'h00);
        rchk(ra, 8'h00);
    endtask
    task automatic t_prio;
        w(ah, 8'h04);
        w(al, 8'h06);
        rchk(ah, 8'h04);
        pa <= 8'hf9;
        settle;
        rchk(ra, 8'h06);
        w(ct, 8'h80);
        settle;
        chk(claim, {1'b1, 1'b0, 3'h2, piep_pkg::PIEP_LEVEL3});
        chk(cpu_irq, 1'b1);
        ack_en <= 1'b1;
        settle;
        rchk(ra, 8'h02);
        ack_en <= 1'b0;
        pa <= 8'hff;
    endtask
    task automatic t_src;
        w(al, 8'h00);
        w(ct, 8'h41);
        w(ra, 8'h00);
        w(al, 8'h41);
        pa <= 8'hbe;
        settle;
        rchk(ra, 8'h00);
        cmp <= 1'b0;
        pd <= 6'h3e;
        settle;
        rchk(ra, 8'h41);
        w(ch, 8'h08);
        w(cl, 8'h08);
        pc <= 4'h7;
        settle;
        rchk(rc, 8'h08);
        w(ct, 8'h80);
        settle;
        chk(claim, {1'b1, 1'b1, 3'h3, piep_pkg::PIEP_LEVEL3});
        ack_en <= 1'b1;
        settle;
        rchk(rc, 8'h00);
        ack_en <= 1'b0;
    endtask
    task automatic t_irq;
        chk(irq_out, 1'b0);
        rchk(st, 8'h01);
        w(mk, 8'h01);
        chk(irq_out, 1'b1);
        w(st, 8'h01);
        chk(irq_out, 1'b0);
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        t_reset;
        t_edges;
        t_prio;
        t_src;
        t_irq;
        print_verdict;
    end
    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        print_verdict;
    end
endmodule // port_interrupt_enable_priority_test
